// *** ptpc_pkg.sv ***
/*
 * Constants, field layout and codes for the periodic timer with pulse and capture modes.
 * Assumes a 100 MHz system clock and an AXI4-Lite register slave with 32-bit data.
 */
package ptpc_pkg;
   localparam int CNT_W = 10;
   localparam int REG_W = 8;
   localparam int ADDR_W = 8;
   localparam int PRE_W = 6;
   typedef logic [CNT_W-1:0] ptpc_count_t;
   localparam ptpc_count_t CNT_ZERO = 10'h000;
   localparam ptpc_count_t CNT_ONE = 10'h001;
   localparam ptpc_count_t CNT_MAX = 10'h3FF;
   // Register byte addresses.
   localparam logic [ADDR_W-1:0] OFS_CTRL_RUN = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CTRL_MODE = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_COUNT_LOW = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_COUNT_HIGH = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_CMP_A_LOW = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_CMP_A_HIGH = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_CMP_P_LOW = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_CMP_P_HIGH = 8'h1C;
   localparam logic [REG_W-1:0] CTRL_RUN_RESET = 8'h00;
   localparam logic [REG_W-1:0] CTRL_MODE_RESET = 8'h00;
   localparam logic [REG_W-1:0] CTRL_RUN_MASK = 8'hF8;
   localparam ptpc_count_t CMP_RESET = 10'h000;
   // Field positions in the run/clock control register.
   localparam int CR_PAUSE_BIT = 7;
   localparam int CR_CLK_HI = 6;
   localparam int CR_CLK_LO = 4;
   localparam int CR_ON_BIT = 3;
   // Field positions in the mode/output control register.
   localparam int CM_MODE_HI = 7;
   localparam int CM_MODE_LO = 6;
   localparam int CM_OUTF_HI = 5;
   localparam int CM_OUTF_LO = 4;
   localparam int CM_INIT_BIT = 3;
   localparam int CM_INV_BIT = 2;
   localparam int CM_CAPSRC_BIT = 1;
   localparam int CM_CLR_BIT = 0;
   // Operating modes.
   localparam logic [1:0] MODE_COMPARE = 2'h0;
   localparam logic [1:0] MODE_CAPTURE = 2'h1;
   localparam logic [1:0] MODE_PULSE = 2'h2;
   localparam logic [1:0] MODE_TIMER = 2'h3;
   // Function field codes: capture edges, then output functions.
   localparam logic [1:0] CAP_RISE = 2'h0;
   localparam logic [1:0] CAP_FALL = 2'h1;
   localparam logic [1:0] CAP_BOTH = 2'h2;
   localparam logic [1:0] CAP_OFF = 2'h3;
   localparam logic [1:0] OUTF_CMP_LOW = 2'h1;
   localparam logic [1:0] OUTF_CMP_HIGH = 2'h2;
   localparam logic [1:0] OUTF_CMP_TOGGLE = 2'h3;
   localparam logic [1:0] OUTF_FORCE_ACTIVE = 2'h1;
   localparam logic [1:0] OUTF_SINGLE_PULSE = 2'h3;
   // Counter clock sources.
   localparam logic [2:0] CLK_SYS_DIV4 = 3'h0;
   localparam logic [2:0] CLK_SYS = 3'h1;
   localparam logic [2:0] CLK_HIGH_DIV16 = 3'h2;
   localparam logic [2:0] CLK_HIGH_DIV64 = 3'h3;
   localparam logic [2:0] CLK_TIME_BASE = 3'h4;
   localparam logic [2:0] CLK_HIGH = 3'h5;
   localparam logic [2:0] CLK_EXT_RISE = 3'h6;
   localparam logic [2:0] CLK_EXT_FALL = 3'h7;
   localparam logic [PRE_W-1:0] DIV4_MASK = 6'h03;
   localparam logic [PRE_W-1:0] DIV16_MASK = 6'h0F;
   localparam logic [PRE_W-1:0] DIV64_MASK = 6'h3F;
   localparam logic [PRE_W-1:0] PRE_STEP = 6'h01;
   localparam logic [PRE_W-1:0] PRE_RESET = 6'h00;
   // Bus answers.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ptpc_pkg

// *** ptpc_tick_if.sv ***
/*
 * Interface carrying clock source selection and the count tick between timer modules.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface ptpc_tick_if;
   logic [2:0] clk_src;
   logic ext_rise;
   logic ext_fall;
   logic tbc_tick;
   logic run;
   logic tick;
   modport gen (input clk_src, input ext_rise, input ext_fall, input tbc_tick, input run,
      output tick);
   modport core (output clk_src, output ext_rise, output ext_fall, output tbc_tick,
      output run, input tick);
endinterface : ptpc_tick_if
`default_nettype wire

// *** ptpc_tick_gen.sv ***
/*
 * Counter clock source selection: prescaled internal clocks, time base and pin edges.
 * Assumes the high clock equals the system clock and pin edges arrive as one-cycle pulses.
 */
`timescale 1ns/1ps
`default_nettype none
module ptpc_tick_gen
   import ptpc_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic NRST,
   ptpc_tick_if.gen t
);
   logic [PRE_W-1:0] pre_reg;

   function automatic logic pre_hit(input logic [PRE_W-1:0] pre, input logic [PRE_W-1:0] mask);
      pre_hit = (pre & mask) == mask;
   endfunction : pre_hit

   // Free running prescaler shared by all divided sources.
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         pre_reg <= PRE_RESET;
      end else begin
         pre_reg <= pre_reg + PRE_STEP;
      end
   end

   // One tick selects one count step while the counter runs.
   always_comb begin
      t.tick = 1'b0;
      unique case (t.clk_src)
         CLK_SYS_DIV4: t.tick = pre_hit(pre_reg, DIV4_MASK); // [RULE19]
         CLK_SYS: t.tick = 1'b1;
         CLK_HIGH_DIV16: t.tick = pre_hit(pre_reg, DIV16_MASK);
         CLK_HIGH_DIV64: t.tick = pre_hit(pre_reg, DIV64_MASK);
         CLK_TIME_BASE: t.tick = t.tbc_tick;
         CLK_HIGH: t.tick = 1'b1;
         CLK_EXT_RISE: t.tick = t.ext_rise;
         CLK_EXT_FALL: t.tick = t.ext_fall;
      endcase
      t.tick = t.tick & t.run; // [RULE18]
   end
endmodule : ptpc_tick_gen
`default_nettype wire

// *** ptpc_top.sv ***
/*
 * Ten-bit periodic timer with compare, single pulse and capture modes behind AXI4-Lite.
 * Assumes pins synchronous to SYS_CLK and a master that keeps AXI4-Lite handshakes.
 */
// Behaviour
// [RULE1] Single pulse needs mode 10 and function 11.
// [RULE2] Pin edge sets counter_on in single pulse.
// [RULE3] counter_on rise starts count and pulse edge.
// [RULE4] Software clear or A match ends pulse.
// [RULE5] A match in single pulse requests interrupt.
// [RULE6] Single pulse clears only on counter_on rise.
// [RULE7] Capture needs mode 01 then counter_on.
// [RULE8] Function bits pick capture edge type.
// [RULE9] Function 11 disables capture, counter keeps running.
// [RULE10] Capture copies count into A, requests interrupt.
// [RULE11] Capture counter runs until counter_on falls.
// [RULE12] P match clears counter and requests interrupt.
// [RULE13] P zero lets counter reach full count.
// [RULE14] Capture sees pin edges even when driving.
// [RULE15] Capture mode drives no output function.
// [RULE16] Ten-bit up counter with comparators A, P.
// [RULE17] Counter never loaded; clears by rise, match, overflow.
// [RULE18] Pause freezes count; resume from held value.
// [RULE19] Clock source select picks eight counter clocks.
// [RULE20] counter_on rise zeroes count; fall holds it.
// [RULE21] Compare mode rise restores initial output level.
// [RULE22] Count read only; A and P read/write pairs.
// [RULE23] Capture edge codes: rise, fall, both, off.
// [RULE24] Capture source: io pin or clock pin.
// [RULE25] Initial level sets polarity; invert flips pin.
// [RULE26] Match strobes when counter equals compare value.
// [RULE27] Pin edge sets counter_on only in single pulse.
`timescale 1ns/1ps
`default_nettype none
module ptpc_top
   import ptpc_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic NRST,
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic EXT_CLK_PIN,
   input wire logic TBC_TICK,
   input wire logic IO_PIN_I,
   output logic IO_PIN_O,
   output logic IO_PIN_OE,
   output logic IRQ_A,
   output logic IRQ_P
);
   ptpc_tick_if tick_if ();

   logic [REG_W-1:0] ctrl_run_reg;
   logic [REG_W-1:0] ctrl_mode_reg;
   ptpc_count_t cmp_a_reg;
   ptpc_count_t cmp_p_reg;
   ptpc_count_t count_reg;
   logic on_prev_reg;
   logic ext_prev_reg;
   logic io_prev_reg;
   logic out_level_reg;
   logic oe_reg;
   logic irq_a_reg;
   logic irq_p_reg;
   logic aw_held_reg;
   logic [ADDR_W-1:0] awaddr_reg;
   logic w_held_reg;
   logic [REG_W-1:0] wdata_reg;
   logic wstrb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;

   logic aw_take;
   logic w_take;
   logic wr_fire;
   logic [ADDR_W-1:0] wr_addr;
   logic [REG_W-1:0] wr_data;
   logic wr_lane;
   logic wr_en;
   logic [REG_W-1:0] rd_byte;
   logic counter_on;
   logic on_next;
   logic on_rise;
   logic run;
   logic step;
   logic [1:0] mode;
   logic [1:0] outf;
   logic pulse_mode;
   logic p_zero;
   logic match_a;
   logic match_p;
   logic overflow;
   logic ext_rise;
   logic ext_fall;
   logic ext_start;
   logic pulse_stop;
   logic cap_level;
   logic cap_prev;
   logic capture;
   logic out_level_next;

   function automatic logic addr_is(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] ofs);
      addr_is = addr == ofs;
   endfunction : addr_is

   function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
      addr_mapped = addr_is(addr, OFS_CTRL_RUN) || addr_is(addr, OFS_CTRL_MODE) ||
                    addr_is(addr, OFS_COUNT_LOW) || addr_is(addr, OFS_COUNT_HIGH) ||
                    addr_is(addr, OFS_CMP_A_LOW) || addr_is(addr, OFS_CMP_A_HIGH) ||
                    addr_is(addr, OFS_CMP_P_LOW) || addr_is(addr, OFS_CMP_P_HIGH);
   endfunction : addr_mapped

   function automatic logic edge_hit(input logic rise, input logic fall, input logic [1:0] sel);
      unique case (sel)
         CAP_RISE: edge_hit = rise;
         CAP_FALL: edge_hit = fall;
         CAP_BOTH: edge_hit = rise | fall;
         CAP_OFF: edge_hit = 1'b0;
      endcase
   endfunction : edge_hit

   // Bus write channel: address and data taken in either order, answer after both.
   assign S_AXI_AWREADY = !aw_held_reg && !bvalid_reg;
   assign S_AXI_WREADY = !w_held_reg && !bvalid_reg;
   assign aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
   assign w_take = S_AXI_WVALID && S_AXI_WREADY;
   assign wr_fire = (aw_held_reg || aw_take) && (w_held_reg || w_take);
   assign wr_addr = aw_held_reg ? awaddr_reg : S_AXI_AWADDR;
   assign wr_data = w_held_reg ? wdata_reg : S_AXI_WDATA[REG_W-1:0];
   assign wr_lane = w_held_reg ? wstrb_reg : S_AXI_WSTRB[0];
   assign wr_en = wr_fire && wr_lane && addr_mapped(wr_addr);
   assign S_AXI_BVALID = bvalid_reg;
   assign S_AXI_BRESP = bresp_reg;

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         aw_held_reg <= 1'b0;
         awaddr_reg <= '0;
         w_held_reg <= 1'b0;
         wdata_reg <= '0;
         wstrb_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else begin
         if (aw_take && !wr_fire) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= S_AXI_AWADDR;
         end
         if (w_take && !wr_fire) begin
            w_held_reg <= 1'b1;
            wdata_reg <= S_AXI_WDATA[REG_W-1:0];
            wstrb_reg <= S_AXI_WSTRB[0];
         end
         if (wr_fire) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= addr_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_reg && S_AXI_BREADY) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // Bus read channel: one read at a time, data registered one cycle after the address.
   always_comb begin
      rd_byte = '0;
      if (addr_is(S_AXI_ARADDR, OFS_CTRL_RUN)) begin
         rd_byte = ctrl_run_reg & CTRL_RUN_MASK; // [RULE22]
      end else if (addr_is(S_AXI_ARADDR, OFS_CTRL_MODE)) begin
         rd_byte = ctrl_mode_reg;
      end else if (addr_is(S_AXI_ARADDR, OFS_COUNT_LOW)) begin
         rd_byte = count_reg[REG_W-1:0]; // [RULE22]
      end else if (addr_is(S_AXI_ARADDR, OFS_COUNT_HIGH)) begin
         rd_byte = {6'h00, count_reg[CNT_W-1:REG_W]};
      end else if (addr_is(S_AXI_ARADDR, OFS_CMP_A_LOW)) begin
         rd_byte = cmp_a_reg[REG_W-1:0];
      end else if (addr_is(S_AXI_ARADDR, OFS_CMP_A_HIGH)) begin
         rd_byte = {6'h00, cmp_a_reg[CNT_W-1:REG_W]};
      end else if (addr_is(S_AXI_ARADDR, OFS_CMP_P_LOW)) begin
         rd_byte = cmp_p_reg[REG_W-1:0];
      end else if (addr_is(S_AXI_ARADDR, OFS_CMP_P_HIGH)) begin
         rd_byte = {6'h00, cmp_p_reg[CNT_W-1:REG_W]};
      end
   end

   assign S_AXI_ARREADY = !rvalid_reg;
   assign S_AXI_RVALID = rvalid_reg;
   assign S_AXI_RDATA = rdata_reg;
   assign S_AXI_RRESP = rresp_reg;

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= RESP_OKAY;
      end else if (S_AXI_ARVALID && !rvalid_reg) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= {24'h000000, rd_byte};
         rresp_reg <= addr_mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && S_AXI_RREADY) begin
         rvalid_reg <= 1'b0;
      end
   end

   // Field decode.
   assign counter_on = ctrl_run_reg[CR_ON_BIT];
   assign mode = ctrl_mode_reg[CM_MODE_HI:CM_MODE_LO];
   assign outf = ctrl_mode_reg[CM_OUTF_HI:CM_OUTF_LO];
   assign pulse_mode = (mode == MODE_PULSE) && (outf == OUTF_SINGLE_PULSE);
   assign on_rise = counter_on && !on_prev_reg;
   assign run = counter_on && !ctrl_run_reg[CR_PAUSE_BIT]; // [RULE18] [RULE20]
   assign p_zero = cmp_p_reg == CNT_ZERO;

   // Pin edges, pins being synchronous already.
   assign ext_rise = EXT_CLK_PIN && !ext_prev_reg;
   assign ext_fall = !EXT_CLK_PIN && ext_prev_reg;

   // Counter clock source.
   assign tick_if.clk_src = ctrl_run_reg[CR_CLK_HI:CR_CLK_LO];
   assign tick_if.ext_rise = ext_rise;
   assign tick_if.ext_fall = ext_fall;
   assign tick_if.tbc_tick = TBC_TICK;
   assign tick_if.run = run;
   assign step = tick_if.tick && !on_rise;

   ptpc_tick_gen u_tick_gen (
      .SYS_CLK(SYS_CLK),
      .NRST(NRST),
      .t(tick_if.gen)
   );

   // Comparators strobe on the counted step taken at the matching value.
   assign match_a = step && (count_reg == cmp_a_reg); // [RULE26] [RULE16]
   assign match_p = step && !p_zero && (count_reg == cmp_p_reg); // [RULE26]
   assign overflow = step && (count_reg == CNT_MAX);

   // Single pulse start and stop.
   assign ext_start = pulse_mode && !counter_on && // [RULE2] [RULE27]
                      ((tick_if.clk_src == CLK_EXT_FALL) ? ext_fall : ext_rise);
   assign pulse_stop = pulse_mode && match_a; // [RULE4]

   always_comb begin
      on_next = counter_on;
      if (wr_en && addr_is(wr_addr, OFS_CTRL_RUN)) begin
         on_next = wr_data[CR_ON_BIT];
      end
      if (pulse_stop) begin
         on_next = 1'b0; // [RULE4]
      end
      if (ext_start) begin
         on_next = 1'b1; // [RULE2]
      end
   end

   // Control registers; unimplemented low bits of run control read zero.
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         ctrl_run_reg <= CTRL_RUN_RESET;
         ctrl_mode_reg <= CTRL_MODE_RESET;
      end else begin
         if (wr_en && addr_is(wr_addr, OFS_CTRL_RUN)) begin
            ctrl_run_reg <= wr_data & CTRL_RUN_MASK;
         end
         ctrl_run_reg[CR_ON_BIT] <= on_next;
         if (wr_en && addr_is(wr_addr, OFS_CTRL_MODE)) begin
            ctrl_mode_reg <= wr_data;
         end
      end
   end

   // Capture trigger from the selected pin, watched even while the pin drives.
   assign cap_level = ctrl_mode_reg[CM_CAPSRC_BIT] ? EXT_CLK_PIN : IO_PIN_I; // [RULE24] [RULE14]
   assign cap_prev = ctrl_mode_reg[CM_CAPSRC_BIT] ? ext_prev_reg : io_prev_reg;
   assign capture = (mode == MODE_CAPTURE) && counter_on && // [RULE8] [RULE9] [RULE23]
                    edge_hit(cap_level && !cap_prev, !cap_level && cap_prev, outf);

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         on_prev_reg <= 1'b0;
         ext_prev_reg <= 1'b0;
         io_prev_reg <= 1'b0;
      end else begin
         on_prev_reg <= counter_on;
         ext_prev_reg <= EXT_CLK_PIN;
         io_prev_reg <= IO_PIN_I;
      end
   end

   // Compare values; a capture wins over a software write in the same cycle.
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         cmp_a_reg <= CMP_RESET;
         cmp_p_reg <= CMP_RESET;
      end else begin
         if (capture) begin
            cmp_a_reg <= count_reg; // [RULE10]
         end else if (wr_en && addr_is(wr_addr, OFS_CMP_A_LOW)) begin
            cmp_a_reg[REG_W-1:0] <= wr_data; // [RULE22]
         end else if (wr_en && addr_is(wr_addr, OFS_CMP_A_HIGH)) begin
            cmp_a_reg[CNT_W-1:REG_W] <= wr_data[CNT_W-REG_W-1:0];
         end
         if (wr_en && addr_is(wr_addr, OFS_CMP_P_LOW)) begin
            cmp_p_reg[REG_W-1:0] <= wr_data;
         end else if (wr_en && addr_is(wr_addr, OFS_CMP_P_HIGH)) begin
            cmp_p_reg[CNT_W-1:REG_W] <= wr_data[CNT_W-REG_W-1:0];
         end
      end
   end

   // Counter: only cleared, never loaded by software.
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         count_reg <= CNT_ZERO;
      end else if (on_rise) begin
         count_reg <= CNT_ZERO; // [RULE20] [RULE3] [RULE17]
      end else if (step) begin
         if (pulse_mode) begin
            count_reg <= count_reg + CNT_ONE; // [RULE6]
         end else if (mode == MODE_CAPTURE) begin
            count_reg <= match_p ? CNT_ZERO : count_reg + CNT_ONE; // [RULE12] [RULE13] [RULE11]
         end else if (ctrl_mode_reg[CM_CLR_BIT]) begin
            count_reg <= match_a ? CNT_ZERO : count_reg + CNT_ONE; // [RULE17]
         end else begin
            count_reg <= match_p ? CNT_ZERO : count_reg + CNT_ONE; // [RULE17]
         end
      end
   end

   // Interrupt request strobes.
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         irq_a_reg <= 1'b0;
         irq_p_reg <= 1'b0;
      end else if (mode == MODE_CAPTURE) begin
         irq_a_reg <= capture; // [RULE10]
         irq_p_reg <= match_p || (p_zero && overflow); // [RULE12]
      end else if (pulse_mode) begin
         irq_a_reg <= match_a; // [RULE5]
         irq_p_reg <= 1'b0; // [RULE6]
      end else begin
         irq_a_reg <= match_a;
         irq_p_reg <= !ctrl_mode_reg[CM_CLR_BIT] && (match_p || (p_zero && overflow));
      end
   end

   assign IRQ_A = irq_a_reg;
   assign IRQ_P = irq_p_reg;

   // Output level before polarity inversion.
   always_comb begin
      out_level_next = out_level_reg;
      if (pulse_mode) begin
         out_level_next = on_next == ctrl_mode_reg[CM_INIT_BIT]; // [RULE3] [RULE4] [RULE25]
      end else if (mode == MODE_PULSE) begin
         out_level_next = (outf == OUTF_FORCE_ACTIVE) ? ctrl_mode_reg[CM_INIT_BIT] :
                          !ctrl_mode_reg[CM_INIT_BIT];
      end else if (mode == MODE_COMPARE) begin
         if (on_rise) begin
            out_level_next = ctrl_mode_reg[CM_INIT_BIT]; // [RULE21]
         end else if (match_a) begin
            unique case (outf)
               OUTF_CMP_LOW: out_level_next = 1'b0;
               OUTF_CMP_HIGH: out_level_next = 1'b1;
               OUTF_CMP_TOGGLE: out_level_next = !out_level_reg;
               default: out_level_next = out_level_reg;
            endcase
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         out_level_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else begin
         out_level_reg <= out_level_next;
         oe_reg <= (mode == MODE_COMPARE) || (mode == MODE_PULSE); // [RULE15]
      end
   end

   assign IO_PIN_O = oe_reg && (out_level_reg ^ ctrl_mode_reg[CM_INV_BIT]); // [RULE25]
   assign IO_PIN_OE = oe_reg;
endmodule : ptpc_top
`default_nettype wire

// *** ptpc_pins.sv ***
/* Far-side pin model of the timer; assumes the bench sets the wanted pin levels. */
`timescale 1ns/1ps
`default_nettype none
module ptpc_pins (
   input wire logic ext_lvl,
   input wire logic io_lvl,
   input wire logic io_o,
   input wire logic io_oe,
   output logic ext_pin,
   output logic io_pin
);
   assign ext_pin = ext_lvl;
   // The shared wire follows the timer while it drives, so capture can see it.
   assign io_pin = io_oe ? io_o : io_lvl;
endmodule : ptpc_pins
`default_nettype wire

// *** ptpc_chk.sv ***
/* Port timing checks for the timer; assumes it is bound into ptpc_top. */
`timescale 1ns/1ps
`default_nettype none
module ptpc_chk (
   input wire logic SYS_CLK,
   input wire logic NRST,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [1:0] S_AXI_BRESP,
   input wire logic IO_PIN_O,
   input wire logic IO_PIN_OE,
   input wire logic IRQ_A,
   input wire logic IRQ_P
);
   default clocking dc @(posedge SYS_CLK);
   endclocking
   default disable iff (!NRST);
   a_irq_a_pulse: assert property (IRQ_A |=> !IRQ_A)
      else $error("IRQ_A too long");
   a_irq_p_pulse: assert property (IRQ_P |=> !IRQ_P)
      else $error("IRQ_P too long");
   a_pin_quiet: assert property (!IO_PIN_OE |-> !IO_PIN_O)
      else $error("pin driven when off");
   a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
      S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write answer dropped");
   a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
      S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read answer dropped");
   a_r_upper: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
      else $error("read upper bits set");
   a_r_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read answer late");
   a_r_clear: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
      else $error("read answer repeated");
   c_irq_a: cover property (IRQ_A);
   c_irq_p: cover property (IRQ_P);
   c_slverr: cover property (S_AXI_BVALID && S_AXI_BRESP == 2'h2);
endmodule : ptpc_chk
bind ptpc_top ptpc_chk i_chk (.SYS_CLK(SYS_CLK), .NRST(NRST), .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
   .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
   .S_AXI_BRESP(S_AXI_BRESP), .IO_PIN_O(IO_PIN_O), .IO_PIN_OE(IO_PIN_OE), .IRQ_A(IRQ_A),
   .IRQ_P(IRQ_P));
`default_nettype wire

// *** periodic_timer_pulse_capture_test.sv ***
/* Self-checking bench for the timer; assumes ptpc_top, its checker and the pin model. */
`timescale 1ns/1ps
`default_nettype none
module periodic_timer_pulse_capture_test
   import ptpc_pkg::*;
;
   logic clk = 1'b0, nrst = 1'b0, awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
   logic el = 1'b0, il = 1'b0, awy, wy, bv, ary, rv, po, poe, irqa, irqp, ep, pi;
   logic [7:0] awa = 8'h00, ara = 8'h00, wd = 8'h00;
   logic [1:0] bp, rp;
   logic [31:0] rdat, rnd = 32'h0000003D;
   logic [33:0] exp_q[$];
   int errors = 0, checks = 0, cyc = 0, na = 0, np = 0;
   always #5 clk = ~clk;
   ptpc_top i_dut (.SYS_CLK(clk), .NRST(nrst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
      .S_AXI_AWREADY(awy), .S_AXI_WDATA({24'h000000, wd}), .S_AXI_WSTRB(4'hF),
      .S_AXI_WVALID(wv), .S_AXI_WREADY(wy), .S_AXI_BRESP(bp), .S_AXI_BVALID(bv),
      .S_AXI_BREADY(brd), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(ary),
      .S_AXI_RDATA(rdat), .S_AXI_RRESP(rp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrd),
      .EXT_CLK_PIN(ep), .TBC_TICK(1'b0), .IO_PIN_I(pi), .IO_PIN_O(po), .IO_PIN_OE(poe),
      .IRQ_A(irqa), .IRQ_P(irqp));
   ptpc_pins i_pins (.ext_lvl(el), .io_lvl(il), .io_o(po), .io_oe(poe), .ext_pin(ep),
      .io_pin(pi));
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check
   task automatic print_verdict();
      if (errors == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
      logic ta, tw, tb;
      exp_q.push_back({r, 32'h00000000});
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      brd <= 1'b1;
      do begin
         @(negedge clk);
         ta = awy;
         tw = wy;
         tb = bv;
         @(posedge clk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
      end while (!tb);
      brd <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
      logic ta, tb;
      exp_q.push_back({r, 24'h000000, d});
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rrd <= 1'b1;
      do begin
         @(negedge clk);
         ta = ary;
         tb = rv;
         @(posedge clk);
         if (ta) arv <= 1'b0;
      end while (!tb);
      rrd <= 1'b0;
   endtask : rd
   always @(negedge clk) begin
      if (bv === 1'b1 && brd) check("write answer", {bp, 32'h0}, exp_q.pop_front());
      if (rv === 1'b1 && rrd) check("read answer", {rp, rdat}, exp_q.pop_front());
      if (irqa === 1'b1) na++;
      if (irqp === 1'b1) np++;
      cyc++;
      if (cyc == 5000) begin
         errors++;
         print_verdict();
      end
   end
   initial begin
      int i, k, n0;
      logic [9:0] v;
      logic [9:0] a_exp;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      rd(OFS_CTRL_RUN, 8'h00, RESP_OKAY);
      rd(OFS_CTRL_MODE, 8'h00, RESP_OKAY);
      rd(8'h20, 8'h00, RESP_SLVERR);
      wr(8'h20, 8'h55, RESP_SLVERR);
      wr(OFS_CTRL_RUN, 8'hFF, RESP_OKAY);
      rd(OFS_CTRL_RUN, 8'hF8, RESP_OKAY);
      rd(OFS_COUNT_LOW, 8'h00, RESP_OKAY);
      for (i = 0; i < 2; i++) begin
         rnd = xs(rnd);
         v = rnd[9:0] | {i[0], 9'h000};
         wr(OFS_CMP_A_LOW + 8'(i << 3), v[7:0], RESP_OKAY);
         wr(OFS_CMP_A_HIGH + 8'(i << 3), {6'h00, v[9:8]}, RESP_OKAY);
         rd(OFS_CMP_A_LOW + 8'(i << 3), v[7:0], RESP_OKAY);
         rd(OFS_CMP_A_HIGH + 8'(i << 3), {6'h00, v[9:8]}, RESP_OKAY);
      end
      wr(OFS_CTRL_RUN, 8'h10, RESP_OKAY);
      wr(OFS_CMP_A_LOW, 8'h05, RESP_OKAY);
      wr(OFS_CMP_A_HIGH, 8'h00, RESP_OKAY);
      for (i = 0; i < 2; i++) begin
         wr(OFS_CTRL_MODE, 8'hB8 | 8'(i << 2), RESP_OKAY);
         n0 = na;
         k = 0;
         @(posedge clk);
         el <= 1'b1;
         repeat (30) begin
            @(negedge clk);
            if (po !== i[0]) k++;
         end
         @(posedge clk);
         el <= 1'b0;
         check("pulse width", 34'(k), 34'h7);
         check("pulse irq", 34'(na - n0), 34'h1);
         rd(OFS_CTRL_RUN, 8'h10, RESP_OKAY);
      end
      a_exp = 10'h005;
      for (i = 0; i < 4; i++) begin
         wr(OFS_CTRL_RUN, 8'h60, RESP_OKAY);
         wr(OFS_CTRL_MODE, 8'h40 | 8'(i << 4), RESP_OKAY);
         wr(OFS_CTRL_RUN, 8'h68, RESP_OKAY);
         n0 = na;
         repeat (2 * (i + 2)) begin
            repeat (2) @(posedge clk);
            el <= !el;
         end
         repeat (2) begin
            repeat (6) @(posedge clk);
            il <= !il;
         end
         repeat (6) @(posedge clk);
         if (i < 3) a_exp = 10'(i + 2);
         check("capture irq", 34'(na - n0), 34'(i == 3 ? 0 : (i == 2 ? 2 : 1)));
         rd(OFS_CMP_A_LOW, a_exp[7:0], RESP_OKAY);
      end
      wr(OFS_CTRL_RUN, 8'h60, RESP_OKAY);
      wr(OFS_CMP_P_LOW, 8'h03, RESP_OKAY);
      wr(OFS_CMP_P_HIGH, 8'h00, RESP_OKAY);
      wr(OFS_CTRL_RUN, 8'h18, RESP_OKAY);
      n0 = np;
      repeat (40) @(posedge clk);
      check("period irq", 34'(np - n0), 34'h9);
      wr(OFS_CTRL_RUN, 8'h00, RESP_OKAY);
      repeat (3) @(posedge clk);
      check("queue left", 34'(exp_q.size()), 34'h0);
      print_verdict();
   end
endmodule : periodic_timer_pulse_capture_test
`default_nettype wire
